// ---- cad_add_decode.sv ----
`timescale 1ns/1ns
`include "cad_params.svh"

// Behaviour
// - Decode carry adds 12-17 and extended 18-19
// - Decode plain adds 02-07 and extended 08-09
// - Report fetch and execute cycle counts separately
// - Bit operand is 3 bits, bits 0-7
// - Direct address operand is full 16 bits
// - Extended register operand is 12 bits
// - Immediate operand is one byte
// - Indirect register operand is 8-bit address
// - Working pair index must be even
// - Register pair address must be even
// - Polarity operand is a single bit
// - Register 8 bits, working register 4 bits
// - Flags: computed, kept, or forced clear
module cad_add_decode (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        opValid,
  input  wire logic [7:0]  opcode,
  input  wire logic [15:0] dstRaw,
  input  wire logic [15:0] srcRaw,
  input  wire logic [15:0] directAddressOperand,
  input  wire logic [2:0]  bitSelect,
  input  wire logic        polarityIn,
  input  wire logic        pairCheck,
  output logic             decValid,
  output logic             isAdd,
  output logic             useCarry,
  output logic             passThrough,
  output logic [7:0]       passOpcode,
  output logic [2:0]       dstMode,
  output logic [2:0]       srcMode,
  output logic [11:0]      dstAddr,
  output logic [11:0]      srcAddr,
  output logic             dstWork,
  output logic             srcWork,
  output logic [3:0]       dstWorkIdx,
  output logic [3:0]       srcWorkIdx,
  output logic [7:0]       immediateOperand,
  output logic [15:0]      directAddress,
  output logic [7:0]       bitMask,
  output logic             polarity,
  output logic             pairError,
  output logic [2:0]       fetchCycles,
  output logic [2:0]       execCycles,
  output logic [1:0]       flagCarry,
  output logic [1:0]       flagZero,
  output logic [1:0]       flagSign,
  output logic [1:0]       flagOverflow,
  output logic [1:0]       flagDecimal,
  output logic [1:0]       flagHalf
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                valid;
    logic                isAdd;
    logic                carry;
    logic                pass;
    logic [7:0]          passOp;
    cad_pkg::cad_mode_e  dMode;
    cad_pkg::cad_mode_e  sMode;
    logic [11:0]         dAddr;
    logic [11:0]         sAddr;
    logic                dWork;
    logic                sWork;
    logic [3:0]          dIdx;
    logic [3:0]          sIdx;
    logic [7:0]          imm;
    logic [15:0]         dirAddr;
    logic [7:0]          mask;
    logic                pol;
    logic                pairErr;
    logic [2:0]          fetch;
    logic [2:0]          exec;
    cad_pkg::cad_flag_e  fC;
    cad_pkg::cad_flag_e  fZ;
    cad_pkg::cad_flag_e  fS;
    cad_pkg::cad_flag_e  fV;
    cad_pkg::cad_flag_e  fD;
    cad_pkg::cad_flag_e  fH;
  } cad_state_s;

  cad_state_s state_q;
  cad_state_s state_d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] bitDecode(input logic [2:0] b);
    bitDecode = `CAD_BIT0_MASK << b;
  endfunction

  function automatic logic isAddOp(input logic [7:0] op);
    isAddOp = (op >= `CAD_OP_ADD_RR && op <= `CAD_OP_ADDX_EIM) ||
              (op >= `CAD_OP_ADC_RR && op <= `CAD_OP_ADC_EXT_EIM);
  endfunction

  // ----------------------------------------------------------------
  // Opcode table
  // ----------------------------------------------------------------
  logic               hit;
  cad_pkg::cad_mode_e dm;
  cad_pkg::cad_mode_e sm;
  logic [2:0]         fc;
  logic [2:0]         ec;

  always_comb begin
    hit = isAddOp(opcode);
    dm  = cad_pkg::CAD_MODE_NONE;
    sm  = cad_pkg::CAD_MODE_NONE;
    fc  = `CAD_FETCH_2;
    ec  = `CAD_EXEC_3;
    // Low nibble selects mode; bit 4 only adds carry
    case (opcode[`CAD_NIB_LO])
      4'h2: begin
        dm = cad_pkg::CAD_MODE_WORK;
        sm = cad_pkg::CAD_MODE_WORK;
      end
      4'h3: begin
        dm = cad_pkg::CAD_MODE_WORK;
        sm = cad_pkg::CAD_MODE_IWRK;
        ec = `CAD_EXEC_4;
      end
      4'h4: begin
        dm = cad_pkg::CAD_MODE_REG;
        sm = cad_pkg::CAD_MODE_REG;
        fc = `CAD_FETCH_3;
      end
      4'h5: begin
        dm = cad_pkg::CAD_MODE_REG;
        sm = cad_pkg::CAD_MODE_IREG;
        fc = `CAD_FETCH_3;
        ec = `CAD_EXEC_4;
      end
      4'h6: begin
        dm = cad_pkg::CAD_MODE_REG;
        sm = cad_pkg::CAD_MODE_IMM;
        fc = `CAD_FETCH_3;
      end
      4'h7: begin
        dm = cad_pkg::CAD_MODE_IREG;
        sm = cad_pkg::CAD_MODE_IMM;
        fc = `CAD_FETCH_3;
        ec = `CAD_EXEC_4;
      end
      4'h8: begin
        dm = cad_pkg::CAD_MODE_EXT;
        sm = cad_pkg::CAD_MODE_EXT;
        fc = `CAD_FETCH_4;
      end
      4'h9: begin
        dm = cad_pkg::CAD_MODE_EXT;
        sm = cad_pkg::CAD_MODE_IMM;
        fc = `CAD_FETCH_4;
      end
      default: begin
        dm = cad_pkg::CAD_MODE_NONE;
      end
    endcase
    if (!hit) begin
      dm = cad_pkg::CAD_MODE_NONE;
      sm = cad_pkg::CAD_MODE_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Operand split
  // ----------------------------------------------------------------
  logic [11:0] dA;
  logic [11:0] sA;
  logic        dW;
  logic        sW;
  logic [3:0]  dI;
  logic [3:0]  sI;
  logic        dOdd;
  logic        sOdd;

  cad_operand_split u_dst (
    .mode    (dm),
    .raw     (dstRaw),
    .regAddr (dA),
    .isWork  (dW),
    .workIdx (dI),
    .oddPair (dOdd)
  );

  cad_operand_split u_src (
    .mode    (sm),
    .raw     (srcRaw),
    .regAddr (sA),
    .isWork  (sW),
    .workIdx (sI),
    .oddPair (sOdd)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d       = state_q;
    state_d.valid = opValid;
    if (opValid) begin
      state_d.isAdd = hit;
      state_d.carry = hit && opcode[`CAD_CARRY_BIT];
      state_d.pass  = !hit;
      state_d.passOp = opcode;
      state_d.dMode = dm;
      state_d.sMode = sm;
      state_d.dAddr = dA;
      state_d.sAddr = sA;
      state_d.dWork = dW;
      state_d.sWork = sW;
      state_d.dIdx  = dI;
      state_d.sIdx  = sI;
      state_d.imm   = (sm == cad_pkg::CAD_MODE_IMM) ? srcRaw[`CAD_BYTE_LO] : `CAD_ZERO_BYTE;
      state_d.dirAddr = directAddressOperand;
      state_d.mask  = bitDecode(bitSelect);
      state_d.pol   = polarityIn;
      // Pair forms are odd-checked on the caller's request
      state_d.pairErr = pairCheck && (dOdd || sOdd);
      state_d.fetch = hit ? fc : `CAD_CYC_NONE;
      state_d.exec  = hit ? ec : `CAD_CYC_NONE;
      state_d.fC = hit ? cad_pkg::CAD_FLAG_CALC : cad_pkg::CAD_FLAG_KEEP;
      state_d.fZ = state_d.fC;
      state_d.fS = state_d.fC;
      state_d.fV = state_d.fC;
      state_d.fH = state_d.fC;
      state_d.fD = hit ? cad_pkg::CAD_FLAG_CLEAR : cad_pkg::CAD_FLAG_KEEP;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign decValid         = state_q.valid;
  assign isAdd            = state_q.isAdd;
  assign useCarry         = state_q.carry;
  assign passThrough      = state_q.pass;
  assign passOpcode       = state_q.passOp;
  assign dstMode          = state_q.dMode;
  assign srcMode          = state_q.sMode;
  assign dstAddr          = state_q.dAddr;
  assign srcAddr          = state_q.sAddr;
  assign dstWork          = state_q.dWork;
  assign srcWork          = state_q.sWork;
  assign dstWorkIdx       = state_q.dIdx;
  assign srcWorkIdx       = state_q.sIdx;
  assign immediateOperand = state_q.imm;
  assign directAddress    = state_q.dirAddr;
  assign bitMask          = state_q.mask;
  assign polarity         = state_q.pol;
  assign pairError        = state_q.pairErr;
  assign fetchCycles      = state_q.fetch;
  assign execCycles       = state_q.exec;
  assign flagCarry        = state_q.fC;
  assign flagZero         = state_q.fZ;
  assign flagSign         = state_q.fS;
  assign flagOverflow     = state_q.fV;
  assign flagDecimal      = state_q.fD;
  assign flagHalf         = state_q.fH;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_xcarry_in;
    opValid && opcode == `CAD_OP_ADC_EXT_EE;
  endsequence

  sequence s_xcarry_out;
    decValid && useCarry && fetchCycles == `CAD_FETCH_4 && execCycles == `CAD_EXEC_3;
  endsequence

  a_xcarry_counts: assert property (@(posedge clk) disable iff (!reset_n) s_xcarry_in |=> s_xcarry_out)
    else $error("extended carry add counts wrong");

  a_add_nocarry: assert property (@(posedge clk) disable iff (!reset_n)
    opValid && opcode == `CAD_OP_ADD_GG |=> isAdd && !useCarry && flagDecimal == cad_pkg::CAD_FLAG_CLEAR)
    else $error("plain add decode wrong");

  a_rr_counts: assert property (@(posedge clk) disable iff (!reset_n)
    opValid && opcode == `CAD_OP_ADC_GG |=> fetchCycles == `CAD_FETCH_3 && execCycles == `CAD_EXEC_3)
    else $error("register carry add counts wrong");

  a_bit_mask: assert property (@(posedge clk) disable iff (!reset_n)
    opValid |=> $onehot(bitMask) && bitMask[$past(bitSelect)])
    else $error("bit mask wrong");

  a_ext_addr: assert property (@(posedge clk) disable iff (!reset_n)
    opValid && opcode == `CAD_OP_ADC_EXT_EE |=> dstAddr == $past(dstRaw[11:0]))
    else $error("extended address wrong");

  a_imm_byte: assert property (@(posedge clk) disable iff (!reset_n)
    opValid && opcode == `CAD_OP_ADC_GIM |=> immediateOperand == $past(srcRaw[7:0]))
    else $error("immediate wrong");

  a_work_escape: assert property (@(posedge clk) disable iff (!reset_n)
    opValid && opcode == `CAD_OP_ADD_GG && dstRaw[7:4] == 4'hE |=> dstWork && dstWorkIdx == $past(dstRaw[3:0]))
    else $error("working escape missed");

  a_pass_other: assert property (@(posedge clk) disable iff (!reset_n)
    opValid && !isAddOp(opcode) |=> passThrough && !isAdd && fetchCycles == 3'h0)
    else $error("pass through wrong");

  a_pair_odd: assert property (@(posedge clk) disable iff (!reset_n)
    opValid && pairCheck && hit && srcRaw[0] |=> pairError)
    else $error("odd pair not flagged");

  a_flag_calc: assert property (@(posedge clk) disable iff (!reset_n)
    opValid && hit |=> flagCarry == cad_pkg::CAD_FLAG_CALC && flagHalf == cad_pkg::CAD_FLAG_CALC)
    else $error("flag action wrong");

endmodule

// ---- cad_add_decode_test.sv ----
`timescale 1ns/1ns

module cad_add_decode_test;
  logic        clk, reset_n, opValid, polarityIn, pairCheck;
  logic [7:0]  opcode;
  logic [15:0] dstRaw, srcRaw, directAddressOperand;
  logic [2:0]  bitSelect;
  logic        decValid, isAdd, useCarry, passThrough, dstWork, srcWork, polarity, pairError;
  logic [7:0]  passOpcode, immediateOperand, bitMask;
  logic [2:0]  dstMode, srcMode, fetchCycles, execCycles;
  logic [11:0] dstAddr, srcAddr;
  logic [3:0]  dstWorkIdx, srcWorkIdx;
  logic [15:0] directAddress;
  logic [1:0]  flagCarry, flagZero, flagSign, flagOverflow, flagDecimal, flagHalf;
  int          fails, checks, cycles;
  logic [7:0]  opTab[16] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
                            8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19};
  logic [2:0]  dmTab[8] = '{3'h1, 3'h1, 3'h3, 3'h3, 3'h3, 3'h4, 3'h6, 3'h6};
  logic [2:0]  smTab[8] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h5, 3'h6, 3'h5};
  logic [2:0]  fcTab[8] = '{3'h2, 3'h2, 3'h3, 3'h3, 3'h3, 3'h3, 3'h4, 3'h4};
  logic [2:0]  ecTab[8] = '{3'h3, 3'h4, 3'h3, 3'h4, 3'h3, 3'h4, 3'h3, 3'h3};

  cad_fetch_model fetch_u (.clk, .opValid, .opcode, .dstRaw, .srcRaw, .directAddressOperand, .bitSelect,
                           .polarityIn, .pairCheck);

  cad_add_decode dut_u (.clk, .reset_n, .opValid, .opcode, .dstRaw, .srcRaw, .directAddressOperand,
    .bitSelect, .polarityIn, .pairCheck, .decValid, .isAdd, .useCarry, .passThrough, .passOpcode,
    .dstMode, .srcMode, .dstAddr, .srcAddr, .dstWork, .srcWork, .dstWorkIdx, .srcWorkIdx,
    .immediateOperand, .directAddress, .bitMask, .polarity, .pairError, .fetchCycles, .execCycles,
    .flagCarry, .flagZero, .flagSign, .flagOverflow, .flagDecimal, .flagHalf);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Hang guard, roughly 27 times the expected run of about 110 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic check_add(input int i);
    int j;
    j = i % 8;
    chk("decValid", 16'h0001, 16'(decValid));
    chk("isAdd", 16'h0001, 16'(isAdd));
    chk("passThrough", 16'h0000, 16'(passThrough));
    chk("useCarry", 16'(i / 8), 16'(useCarry));
    chk("dstMode", 16'(dmTab[j]), 16'(dstMode));
    chk("srcMode", 16'(smTab[j]), 16'(srcMode));
    chk("fetchCycles", 16'(fcTab[j]), 16'(fetchCycles));
    chk("execCycles", 16'(ecTab[j]), 16'(execCycles));
    chk("flags", 16'h0559, {4'h0, flagCarry, flagZero, flagSign, flagOverflow, flagDecimal, flagHalf});
    chk("immediate", (smTab[j] == 3'h5) ? 16'h0045 : 16'h0000, 16'(immediateOperand));
    chk("dstWork", 16'(dmTab[j] == 3'h1), 16'(dstWork));
    chk("srcWork", 16'(smTab[j] == 3'h1 || smTab[j] == 3'h2), 16'(srcWork));
  endtask

  // Every add opcode, back to back
  task automatic t_all_adds();
    for (int i = 0; i < 16; i++) begin
      fetch_u.send(opTab[i], 16'h0123, 16'h0045, 16'h0000, 3'h0, 1'b0, 1'b0);
      if (i > 0) check_add(i - 1);
    end
    fetch_u.idle();
    check_add(15);
    fetch_u.idle();
    chk("decValid", 16'h0000, 16'(decValid));
  endtask

  task automatic t_operands();
    for (int b = 0; b < 8; b++) begin
      fetch_u.send(8'h18, b[0] ? 16'h0FFF : 16'h0000, b[0] ? 16'h0000 : 16'h0FFF,
                   b[0] ? 16'hFFFF : 16'h0000, 3'(b), b[0], 1'b0);
      fetch_u.idle();
      chk("dstAddr", b[0] ? 16'h0FFF : 16'h0000, 16'(dstAddr));
      chk("srcAddr", b[0] ? 16'h0000 : 16'h0FFF, 16'(srcAddr));
      chk("directAddress", b[0] ? 16'hFFFF : 16'h0000, directAddress);
      chk("bitMask", 16'(8'h01 << b), 16'(bitMask));
      chk("polarity", 16'(b[0]), 16'(polarity));
    end
    for (int k = 0; k < 2; k++) begin
      fetch_u.send(8'h16, 16'h00E5, k ? 16'h00FF : 16'h0000, 16'h0000, 3'h0, 1'b0, 1'b0);
      fetch_u.idle();
      chk("dstWork", 16'h0001, 16'(dstWork));
      chk("dstWorkIdx", 16'h0005, 16'(dstWorkIdx));
      chk("immediate", k ? 16'h00FF : 16'h0000, 16'(immediateOperand));
    end
    fetch_u.send(8'h15, 16'h00FF, 16'h0080, 16'h0000, 3'h0, 1'b0, 1'b0);
    fetch_u.idle();
    chk("dstWork", 16'h0000, 16'(dstWork));
    chk("srcWork", 16'h0000, 16'(srcWork));
    chk("dstAddr", 16'h00FF, 16'(dstAddr));
    chk("srcAddr", 16'h0080, 16'(srcAddr));
    fetch_u.send(8'h03, 16'h0007, 16'h000F, 16'h0000, 3'h0, 1'b0, 1'b0);
    fetch_u.idle();
    chk("dstWorkIdx", 16'h0007, 16'(dstWorkIdx));
    chk("srcWorkIdx", 16'h000F, 16'(srcWorkIdx));
    // Escape on both sides of a register to register add
    fetch_u.send(8'h04, 16'h00E3, 16'h00EA, 16'h0000, 3'h0, 1'b0, 1'b0);
    fetch_u.idle();
    chk("dstWork", 16'h0001, 16'(dstWork));
    chk("srcWork", 16'h0001, 16'(srcWork));
    chk("dstWorkIdx", 16'h0003, 16'(dstWorkIdx));
    chk("srcWorkIdx", 16'h000A, 16'(srcWorkIdx));
  endtask

  task automatic t_pairs();
    for (int p = 0; p < 16; p++) begin
      fetch_u.send(8'h13, 16'h0000, 16'(p), 16'h0000, 3'h0, 1'b0, 1'b1);
      fetch_u.idle();
      chk("pairError", 16'(p % 2), 16'(pairError));
    end
    for (int k = 0; k < 3; k++) begin
      fetch_u.send(8'h15, 16'h0000, k ? 16'h00FF : 16'h00FE, 16'h0000, 3'h0, 1'b0, k < 2);
      fetch_u.idle();
      chk("pairError", 16'(k == 1), 16'(pairError));
    end
  endtask

  task automatic t_passthru();
    logic [7:0] ops[6] = '{8'h00, 8'h01, 8'h0A, 8'h10, 8'h1A, 8'hFF};
    foreach (ops[n]) begin
      fetch_u.send(ops[n], 16'h0123, 16'h0045, 16'h0000, 3'h0, 1'b0, 1'b0);
      fetch_u.idle();
      chk("passThrough", 16'h0001, 16'(passThrough));
      chk("isAdd", 16'h0000, 16'(isAdd));
      chk("fetchCycles", 16'h0000, 16'(fetchCycles));
      chk("flags", 16'h0000, {4'h0, flagCarry, flagZero, flagSign, flagOverflow, flagDecimal, flagHalf});
      fetch_u.idle();
      chk("passOpcode", 16'(ops[n]), 16'(passOpcode));
      chk("decValid", 16'h0000, 16'(decValid));
    end
  endtask

  // Asynchronous clear in mid-run
  task automatic t_midrun_reset();
    fetch_u.send(8'h18, 16'h0123, 16'h0045, 16'h0000, 3'h0, 1'b0, 1'b0);
    @(negedge clk);
    reset_n = 1'b0;
    #1;
    chk("decValid", 16'h0000, 16'(decValid));
    chk("fetchCycles", 16'h0000, 16'(fetchCycles));
    chk("dstAddr", 16'h0000, 16'(dstAddr));
    fetch_u.idle();
    reset_n = 1'b1;
    fetch_u.send(8'h12, 16'h0000, 16'h0000, 16'h0000, 3'h0, 1'b0, 1'b0);
    fetch_u.idle();
    chk("fetchCycles", 16'h0002, 16'(fetchCycles));
  endtask

  initial begin
    fails = 0;
    checks = 0;
    cycles = 0;
    reset_n = 1'b0;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    chk("decValid", 16'h0000, 16'(decValid));
    chk("isAdd", 16'h0000, 16'(isAdd));
    t_all_adds();
    t_operands();
    t_pairs();
    t_passthru();
    t_midrun_reset();
    give_verdict();
  end
endmodule

// ---- cad_fetch_model.sv ----
`timescale 1ns/1ns

// ----------------------------------------------------------------
// Fetch unit model
// ----------------------------------------------------------------
module cad_fetch_model (
  input  wire logic clk,
  output logic        opValid,
  output logic [7:0]  opcode,
  output logic [15:0] dstRaw,
  output logic [15:0] srcRaw,
  output logic [15:0] directAddressOperand,
  output logic [2:0]  bitSelect,
  output logic        polarityIn,
  output logic        pairCheck
);
  initial begin
    opValid = 1'b0;
    opcode = 8'h00;
    dstRaw = 16'h0000;
    srcRaw = 16'h0000;
    directAddressOperand = 16'h0000;
    bitSelect = 3'h0;
    polarityIn = 1'b0;
    pairCheck = 1'b0;
  end

  task automatic send(input logic [7:0] op, input logic [15:0] dRaw, input logic [15:0] sRaw,
                      input logic [15:0] dirAddr, input logic [2:0] bs, input logic pol, input logic pc);
    @(negedge clk);
    opValid = 1'b1;
    opcode = op;
    dstRaw = dRaw;
    srcRaw = sRaw;
    directAddressOperand = dirAddr;
    bitSelect = bs;
    polarityIn = pol;
    pairCheck = pc;
  endtask

  // Idle lines flip so a stale value can never pass for a held one
  task automatic idle();
    @(negedge clk);
    opValid = 1'b0;
    opcode = ~opcode;
    dstRaw = ~dstRaw;
    srcRaw = ~srcRaw;
    directAddressOperand = ~directAddressOperand;
    bitSelect = ~bitSelect;
    polarityIn = ~polarityIn;
    pairCheck = ~pairCheck;
  endtask
endmodule

// ---- cad_operand_split.sv ----
`timescale 1ns/1ns
`include "cad_params.svh"

// Combinational operand field extraction for one operand slot
module cad_operand_split (
  input  wire logic [2:0]  mode,
  input  wire logic [15:0] raw,
  output logic      [11:0] regAddr,
  output logic             isWork,
  output logic      [3:0]  workIdx,
  output logic             oddPair
);

  always_comb begin
    regAddr = `CAD_ZERO_EXT;
    isWork  = 1'b0;
    workIdx = raw[`CAD_NIB_LO];
    oddPair = raw[`CAD_PAIR_BIT];
    case (mode)
      cad_pkg::CAD_MODE_WORK, cad_pkg::CAD_MODE_IWRK: begin
        isWork  = 1'b1;
        regAddr = {`CAD_ZERO_BYTE, raw[`CAD_NIB_LO]};
      end
      cad_pkg::CAD_MODE_REG, cad_pkg::CAD_MODE_IREG: begin
        // Upper nibble E escapes into the working bank
        isWork  = (raw[`CAD_NIB_HI] == `CAD_WORK_NIBBLE);
        regAddr = {`CAD_ZERO_NIB, raw[`CAD_BYTE_LO]};
      end
      cad_pkg::CAD_MODE_EXT: begin
        regAddr = raw[`CAD_EXT_LO];
      end
      default: begin
        regAddr = `CAD_ZERO_EXT;
      end
    endcase
  end

endmodule

// ---- cad_params.svh ----
`ifndef CAD_PARAMS_SVH
`define CAD_PARAMS_SVH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define CAD_OP_ADD_RR    8'h02
`define CAD_OP_ADD_RIR   8'h03
`define CAD_OP_ADD_GG    8'h04
`define CAD_OP_ADD_GIG   8'h05
`define CAD_OP_ADD_GIM   8'h06
`define CAD_OP_ADD_IGIM  8'h07
`define CAD_OP_ADDX_EE   8'h08
`define CAD_OP_ADDX_EIM  8'h09
`define CAD_OP_ADC_RR    8'h12
`define CAD_OP_ADC_RIR   8'h13
`define CAD_OP_ADC_GG    8'h14
`define CAD_OP_ADC_GIG   8'h15
`define CAD_OP_ADC_GIM   8'h16
`define CAD_OP_ADC_IGIM  8'h17
`define CAD_OP_ADC_EXT_EE  8'h18
`define CAD_OP_ADC_EXT_EIM 8'h19

// ----------------------------------------------------------------
// Cycle counts
// ----------------------------------------------------------------
`define CAD_FETCH_2      3'h2
`define CAD_FETCH_3      3'h3
`define CAD_FETCH_4      3'h4
`define CAD_EXEC_3       3'h3
`define CAD_EXEC_4       3'h4

// ----------------------------------------------------------------
// Operand fields
// ----------------------------------------------------------------
`define CAD_WORK_NIBBLE  4'hE
`define CAD_NIB_HI       7:4
`define CAD_NIB_LO       3:0
`define CAD_EXT_W        12
`define CAD_ZERO_BYTE    8'h00
`define CAD_ZERO_EXT     12'h000
`define CAD_ZERO_ADDR    16'h0000
`define CAD_ZERO_NIB     4'h0
`define CAD_BYTE_LO      7:0
`define CAD_EXT_LO       11:0
`define CAD_PAIR_BIT     0
`define CAD_CARRY_BIT    4
`define CAD_BIT0_MASK    8'h01
`define CAD_CYC_NONE     3'h0

`endif

// ---- cad_pkg.sv ----
package cad_pkg;

  typedef enum logic [2:0] {
    CAD_MODE_NONE = 3'b000,
    CAD_MODE_WORK = 3'b001,
    CAD_MODE_IWRK = 3'b010,
    CAD_MODE_REG  = 3'b011,
    CAD_MODE_IREG = 3'b100,
    CAD_MODE_IMM  = 3'b101,
    CAD_MODE_EXT  = 3'b110
  } cad_mode_e;

  // Flag action per flag
  typedef enum logic [1:0] {
    CAD_FLAG_KEEP  = 2'b00,
    CAD_FLAG_CALC  = 2'b01,
    CAD_FLAG_CLEAR = 2'b10
  } cad_flag_e;

  typedef enum logic [1:0] {
    CAD_ST_IDLE = 2'b00,
    CAD_ST_HOLD = 2'b01
  } cad_state_e;

  typedef logic [7:0] cad_byte_t;

endpackage
